// >>> design/sbs_sram_port.sv
// Pipelined burst SRAM core: address capture, burst, lane writes, read pipe.
// Assumes the far side runs on clk; only output enable and order are async.
`include "sbs_consts.svh"

module sbs_sram_port
   import sbs_pkg::*;
#(
   parameter int ADDR_W = `SBS_ADDR_W,
   parameter int LANE_W = `SBS_LANE_W,
   parameter bit HAS_THIRD_SELECT = 1'b1
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [ADDR_W-1:0] address,
   input wire sbs_ctrl_t ctrl,
   input wire logic outputEnableN,
   input wire logic burstOrderInterleave,
   input wire logic [`SBS_LANES*LANE_W-1:0] dqIn,
   output logic [`SBS_LANES*LANE_W-1:0] dqOut,
   output logic dqOutEnN
);

   localparam int LANES = `SBS_LANES;
   localparam int DATA_W = LANES * LANE_W;
   localparam int BW = `SBS_BURST_W;
   localparam int DEPTH = 2 ** ADDR_W;

   ////////////////////////////////////////////////////////////////////////
   // Declarations

   logic oeSync1_q;
   logic oeSync2_q;
   logic orderSync1_q;
   logic orderSync2_q;
   sbs_cycle_t cyc_q;
   sbs_cycle_t cyc_d;
   logic [ADDR_W-1:BW] addrHigh_q;
   logic [ADDR_W-1:BW] addrHigh_d;
   logic [DATA_W-1:0] dqOut_q;
   logic [DATA_W-1:0] dqOut_d;
   logic dqOutEnN_q;
   logic dqOutEnN_d;
   logic [LANES-1:0] laneSelN;
   logic [LANES-1:0] laneWe;
   logic procStrobe;
   logic ctrlStrobe;
   logic start;
   logic thirdActive;
   logic selected;
   logic writeReq;
   logic doWrite;
   logic load;
   logic advance;
   logic [BW-1:0] count;
   logic [BW-1:0] countNext;
   logic [ADDR_W-1:0] effAddr;
   logic [ADDR_W-1:0] rdAddr;
   logic [DATA_W-1:0] memRd;

   // Checks share one clock and reset, declared before any of them
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!arst_n);

   ////////////////////////////////////////////////////////////////////////
   // Asynchronous pins pass two flops before any logic reads them
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         oeSync1_q <= `SBS_PIN_OFF;
         oeSync2_q <= `SBS_PIN_OFF;
         orderSync1_q <= `SBS_BIT_CLR;
         orderSync2_q <= `SBS_BIT_CLR;
      end else begin
         oeSync1_q <= outputEnableN;
         oeSync2_q <= oeSync1_q;
         orderSync1_q <= burstOrderInterleave;
         orderSync2_q <= orderSync1_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Strobe and select qualification

   assign laneSelN = {ctrl.laneDWriteSelectN, ctrl.laneCWriteSelectN,
                      ctrl.laneBWriteSelectN, ctrl.laneAWriteSelectN};

   // Missing third select behaves as tied active
   assign thirdActive = HAS_THIRD_SELECT ? !ctrl.chipSelectThirdN
                                         : 1'h1;   // see R9
   assign selected = !ctrl.chipSelectFirstN && ctrl.chipSelectSecond
                     && thirdActive;                // see R7
   // First select high hides the processor strobe entirely
   assign procStrobe = !ctrl.processorAddrStrobeN
                       && !ctrl.chipSelectFirstN;   // see R8
   // Processor strobe wins when both arrive together
   assign ctrlStrobe = !ctrl.controllerAddrStrobeN
                       && !procStrobe;              // see R12
   assign start = procStrobe || ctrlStrobe;
   assign load = start && selected;                 // see R1
   assign advance = !start && (cyc_q != CYC_DESEL)
                    && !ctrl.burstAdvanceN;         // see R6

   // Any write intent: global, or lane enable with at least one select
   assign writeReq = !ctrl.allLanesWriteN
                     || (!ctrl.laneWriteEnableN && !(&laneSelN));

   ////////////////////////////////////////////////////////////////////////
   // Cycle decode: strobes start or deselect, otherwise the burst goes on
   always_comb begin
      cyc_d = cyc_q;
      addrHigh_d = addrHigh_q;
      if (start) begin
         if (!selected) begin
            cyc_d = CYC_DESEL;                      // see R7
         end else begin
            addrHigh_d = address[ADDR_W-1:BW];      // see R1
            // Processor-started cycles always begin as reads
            if (procStrobe) begin
               cyc_d = CYC_READ;                    // see R12
            end else if (writeReq) begin
               cyc_d = CYC_WRITE;
            end else begin
               cyc_d = CYC_READ;
            end
         end
      end else begin
         case (cyc_q)
            CYC_DESEL: begin
               cyc_d = CYC_DESEL;
            end
            CYC_READ, CYC_WRITE: begin
               cyc_d = writeReq ? CYC_WRITE : CYC_READ;
            end
            default: begin
               cyc_d = CYC_DESEL;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cyc_q <= CYC_DESEL;
         addrHigh_q <= '0;
      end else begin
         cyc_q <= cyc_d;
         addrHigh_q <= addrHigh_d;
      end
   end

   // Low address bits come from the burst counter
   sbs_burst_counter #(
      .CNT_W(BW)
   ) u_counter (
      .clk(clk),
      .arst_n(arst_n),
      .load(load),
      .seed(address[BW-1:0]),                       // see R2
      .advance(advance),
      .interleave(orderSync2_q),                    // see R14
      .count(count),
      .countNext(countNext)
   );

   // Writes land on the address of this edge, reads on the last one
   assign effAddr = {addrHigh_d, countNext};
   assign rdAddr = {addrHigh_q, count};
   assign doWrite = (cyc_d == CYC_WRITE);

   ////////////////////////////////////////////////////////////////////////
   // Storage, one flop array per byte lane
   for (genvar i = 0; i < LANES; i++) begin : g_lane
      logic [LANE_W-1:0] memLane [DEPTH];

      // Global write overrides lane selects and lane enable
      assign laneWe[i] = doWrite && (!ctrl.allLanesWriteN      // see R4
                         || (!ctrl.laneWriteEnableN            // see R5
                             && !laneSelN[i]));                // see R3

      // No reset: contents are data, not control state
      always_ff @(posedge clk) begin
         if (laneWe[i]) begin
            memLane[effAddr] <= dqIn[i*LANE_W +: LANE_W];
         end
      end

      assign memRd[i*LANE_W +: LANE_W] = memLane[rdAddr];

      property p_laneStore;
         laneWe[i] |=> memLane[$past(effAddr)]
                       == $past(dqIn[i*LANE_W +: LANE_W]);
      endproperty
      a_laneStore: assert property (p_laneStore) // see R3
         else $error("lane write did not store the sampled data");
   end

   ////////////////////////////////////////////////////////////////////////
   // Read pipe and pin drive, both registered
   always_comb begin
      dqOut_d = dqOut_q;
      if (cyc_q == CYC_READ) begin
         dqOut_d = memRd;                           // see R13
      end
      // After a deselect cyc_q is not a read, so the pins stay off
      dqOutEnN_d = !(!oeSync2_q && (cyc_q == CYC_READ)); // see R10 R11
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         dqOut_q <= '0;
         dqOutEnN_q <= `SBS_PIN_OFF;
      end else begin
         dqOut_q <= dqOut_d;
         dqOutEnN_q <= dqOutEnN_d;
      end
   end

   assign dqOut = dqOut_q;
   assign dqOutEnN = dqOutEnN_q;

   ////////////////////////////////////////////////////////////////////////
   // Checks

   property p_capture;
      load |=> addrHigh_q == $past(address[ADDR_W-1:BW]);
   endproperty
   a_capture: assert property (p_capture) // see R1
      else $error("address not captured on accepted strobe");

   property p_seed;
      load |=> count == $past(address[BW-1:0]);
   endproperty
   a_seed: assert property (p_seed) // see R2
      else $error("burst counter not seeded from low address bits");

   property p_allLanes;
      doWrite && !ctrl.allLanesWriteN |-> &laneWe;
   endproperty
   a_allLanes: assert property (p_allLanes) // see R4
      else $error("global write missed a lane");

   property p_laneMask;
      doWrite && ctrl.allLanesWriteN |-> laneWe ==
         (ctrl.laneWriteEnableN ? '0 : ~laneSelN);
   endproperty
   a_laneMask: assert property (p_laneMask) // see R3
      else $error("lane write enables disagree with selects");

   property p_advance;
      // An order change landing on the next edge reshuffles the count
      advance && !orderSync2_q
         |=> $changed(orderSync2_q) || count == BW'($past(count) + 1'h1);
   endproperty
   a_advance: assert property (p_advance) // see R6
      else $error("linear burst did not step by one");

   property p_hold;
      !start && ctrl.burstAdvanceN
         |=> $stable(addrHigh_q) && ($changed(orderSync2_q) || $stable(count));
   endproperty
   a_hold: assert property (p_hold) // see R6
      else $error("burst address moved without advance");

   property p_interleave;
      advance && orderSync2_q && $stable(orderSync2_q) ##1
      advance && orderSync2_q
         |=> $changed(orderSync2_q) || count == ($past(count, 2) ^ 2'h2);
   endproperty
   a_interleave: assert property (p_interleave) // see R14
      else $error("interleaved step order wrong");

   property p_deselect;
      start && !selected |=> cyc_q == CYC_DESEL ##1 dqOutEnN_q;
   endproperty
   a_deselect: assert property (p_deselect) // see R7
      else $error("unselected strobe did not deselect");

   property p_ignoreProc;
      !ctrl.processorAddrStrobeN && ctrl.chipSelectFirstN
      && ctrl.controllerAddrStrobeN |=> $stable(addrHigh_q);
   endproperty
   a_ignoreProc: assert property (p_ignoreProc) // see R8
      else $error("processor strobe acted on with first select high");

   property p_procWins;
      !ctrl.processorAddrStrobeN && !ctrl.controllerAddrStrobeN
      && selected |=> cyc_q == CYC_READ;
   endproperty
   a_procWins: assert property (p_procWins) // see R12
      else $error("controller strobe won over processor strobe");

   property p_driveCause;
      !dqOutEnN_q |-> $past(cyc_q) == CYC_READ && !$past(oeSync2_q);
   endproperty
   a_driveCause: assert property (p_driveCause) // see R10
      else $error("pins driven outside a read with output enable");

   sequence s_firstRead;
      cyc_q == CYC_DESEL ##1 cyc_q == CYC_READ;
   endsequence

   property p_firstMask;
      s_firstRead |-> dqOutEnN_q;
   endproperty
   a_firstMask: assert property (p_firstMask) // see R11
      else $error("pins driven in first clock after deselect");

   property p_readData;
      cyc_q == CYC_READ |=> dqOut_q == $past(memRd);
   endproperty
   a_readData: assert property (p_readData) // see R13
      else $error("read data not from preceding edge address");

endmodule

// >>> design/sbs_consts.svh
// Constants for the synchronous burst SRAM port: widths and reset values.
// Assumes inclusion by bare name from every design file of the block.
//
// How it works
// R1: Address captured when a strobe is accepted and all chip selects active.
// R2: Low two captured address bits seed the two-bit burst counter.
// R3: A lane writes when its select is low and lane write enable low.
// R4: All-lanes write low writes every lane, ignoring selects and enable.
// R5: Controller holds lane write enable low for any selective byte write.
// R6: Outside strobes and deselect, burst counter steps on edges with advance low, holds otherwise.
// R7: Selected only when first low, second high, third select low.
// R8: Processor strobe ignored while first chip select is high.
// R9: Without a third chip select, that select counts as always active.
// R10: Output enable low drives read data, high leaves the pins undriven.
// R11: First clock of a read after deselect keeps the data pins undriven.
// R12: With both strobes low and first chip select low, only the processor strobe is acted on.
// R13: Read data belongs to the address of the preceding clock edge.
// R14: Burst wraps in four addresses, linear or interleaved by order input.
`ifndef SBS_CONSTS_SVH
`define SBS_CONSTS_SVH

`define SBS_ADDR_W 18
`define SBS_LANES 4
`define SBS_LANE_W 9
`define SBS_BURST_W 2
`define SBS_PIN_OFF 1'h1
`define SBS_BIT_CLR 1'h0

`endif

// >>> design/sbs_pkg.sv
// Types shared by the burst SRAM port files.
// Assumes the constants header sits beside this file.
`include "sbs_consts.svh"

package sbs_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Synchronous control pins, all sampled on the rising clock edge
   typedef struct packed {
      logic processorAddrStrobeN;
      logic controllerAddrStrobeN;
      logic burstAdvanceN;
      logic laneAWriteSelectN;
      logic laneBWriteSelectN;
      logic laneCWriteSelectN;
      logic laneDWriteSelectN;
      logic laneWriteEnableN;
      logic allLanesWriteN;
      logic chipSelectFirstN;
      logic chipSelectSecond;
      logic chipSelectThirdN;
   } sbs_ctrl_t;

   // Kind of cycle begun at the last clock edge
   typedef enum logic [1:0] {
      CYC_DESEL,
      CYC_READ,
      CYC_WRITE
   } sbs_cycle_t;

endpackage

// >>> design/sbs_burst_counter.sv
// Two-bit burst address counter with linear or interleaved order.
// Assumes load and advance are never wanted in the same cycle.
`include "sbs_consts.svh"

module sbs_burst_counter
   import sbs_pkg::*;
#(
   parameter int CNT_W = `SBS_BURST_W
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic load,
   input wire logic [CNT_W-1:0] seed,
   input wire logic advance,
   input wire logic interleave,
   output logic [CNT_W-1:0] count,
   output logic [CNT_W-1:0] countNext
);

   logic [CNT_W-1:0] seed_q;
   logic [CNT_W-1:0] seed_d;
   logic [CNT_W-1:0] step_q;
   logic [CNT_W-1:0] step_d;

   // Wraps inside the group because the sum is cut to CNT_W bits
   function automatic logic [CNT_W-1:0] order(
      input logic [CNT_W-1:0] s,
      input logic [CNT_W-1:0] t,
      input logic il
   );
      order = il ? (s ^ t) : CNT_W'(s + t);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Seed on load, step on advance
   always_comb begin
      seed_d = seed_q;
      step_d = step_q;
      if (load) begin
         seed_d = seed;                      // see R2
         step_d = '0;
      end else if (advance) begin
         step_d = CNT_W'(step_q + 1'h1);     // see R6
      end
   end

   // Order is applied on the way out so a change needs no reload
   assign count = order(seed_q, step_q, interleave);     // see R14
   assign countNext = order(seed_d, step_d, interleave);

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         seed_q <= '0;
         step_q <= '0;
      end else begin
         seed_q <= seed_d;
         step_q <= step_d;
      end
   end

endmodule

// >>> tb/sbs_bus_model.sv
// Data wire between the SRAM port and the bus controller.
// Assumes the controller drives only while the port leaves the pins free.
`include "sbs_consts.svh"

module sbs_bus_model #(
   parameter int DW = `SBS_LANES*`SBS_LANE_W
) (
   input wire logic clk,
   input wire logic [DW-1:0] dqOut,
   input wire logic dqOutEnN,
   input wire logic [DW-1:0] hostData,
   input wire logic hostDrive,
   output logic [DW-1:0] dqWire,
   output logic clash
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [DW-1:0] lastQ = '0;
   ////////////////////////////////////////////////////////////////////
   // Released wire shows no stale value, so a late sample cannot pass
   always_comb begin
      if (!dqOutEnN) dqWire = dqOut;
      else if (hostDrive) dqWire = hostData;
      else dqWire = ~lastQ;
   end
   always_ff @(posedge clk) lastQ <= dqWire;
   assign clash = !dqOutEnN && hostDrive;
endmodule

// >>> tb/sync_burst_sram_port_tb.sv
// Self-checking bench for the burst SRAM port, one task per scenario.
// Assumes the port decodes a shrunk 6-bit address for short runs.
`include "sbs_consts.svh"

module sync_burst_sram_port_tb
   import sbs_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int AW = 6;
   localparam int DW = `SBS_LANES*`SBS_LANE_W;
   localparam sbs_ctrl_t IDLE = 12'hffa;
   localparam sbs_ctrl_t DES = 12'hbfe;
   localparam sbs_ctrl_t RDC = 12'h7fa;
   localparam sbs_ctrl_t GWR = 12'hbf2;
   localparam logic [DW-1:0] D1 = 36'h123456789;
   localparam logic [DW-1:0] LX = {9'h0, 9'h1ff, 9'h0, 9'h1ff};
   logic clk = 1'h0;
   logic arst_n = 1'h0;
   logic [AW-1:0] address = '0;
   sbs_ctrl_t ctrl = IDLE;
   logic outputEnableN = 1'h0;
   logic burstOrderInterleave = 1'h0;
   logic [DW-1:0] hostData = '0;
   logic hostDrive = 1'h0;
   logic [DW-1:0] dqWire;
   logic [DW-1:0] dqOut;
   logic dqOutEnN;
   logic clash;
   int num_errors = 0;
   int n_checks = 0;
   int cycles = 0;

   ////////////////////////////////////////////////////////////////////
   // Clock, design and wire model
   always #2 clk = ~clk;
   sbs_sram_port #(.ADDR_W(AW)) sbs_sram_port_i (.clk(clk),
      .arst_n(arst_n), .address(address), .ctrl(ctrl),
      .outputEnableN(outputEnableN),
      .burstOrderInterleave(burstOrderInterleave), .dqIn(dqWire),
      .dqOut(dqOut), .dqOutEnN(dqOutEnN));
   sbs_bus_model sbs_bus_model_i (.clk(clk), .dqOut(dqOut),
      .dqOutEnN(dqOutEnN), .hostData(hostData), .hostDrive(hostDrive),
      .dqWire(dqWire), .clash(clash));

   // Hang guard and contention watch
   always @(posedge clk) begin
      cycles++;
      if (clash === 1'h1) fail("bus clash");
      if (cycles == 3000) begin
         fail("timeout");
         end_of_test();
      end
   end

   ////////////////////////////////////////////////////////////////////
   task automatic fail(input string msg);
      num_errors++;
      $display("[FAIL] %0t %s", $time, msg);
   endtask
   task automatic chk_data(input logic [DW-1:0] g, input logic [DW-1:0] e);
      n_checks++;
      if (g !== e) fail($sformatf("data %h exp %h", g, e));
   endtask
   task automatic chk_bit(input logic g, input logic e);
      n_checks++;
      if (g !== e) fail($sformatf("drive %b exp %b", g, e));
   endtask
   // One write edge, then a deselect so the pins go free
   task automatic wr(input sbs_ctrl_t c, input logic [AW-1:0] a,
      input logic [DW-1:0] d);
      @(posedge clk);
      ctrl <= c;
      address <= a;
      hostData <= d;
      hostDrive <= 1'h1;
      @(posedge clk);
      ctrl <= DES;
      hostDrive <= 1'h0;
   endtask
   // Read from deselected state; data one edge after capture
   task automatic rd(input sbs_ctrl_t c, input logic [AW-1:0] a,
      input logic [DW-1:0] e, input logic en);
      @(posedge clk);
      ctrl <= c;
      address <= a;
      @(posedge clk);
      ctrl <= DES;
      #1 chk_bit(dqOutEnN, 1'h1);
      @(posedge clk);
      #1 chk_data(dqOut, e);
      chk_bit(dqOutEnN, en);
   endtask

   ////////////////////////////////////////////////////////////////////
   task automatic t_global();
      wr(GWR, 6'h05, D1);
      wr(GWR, 6'h09, ~D1);
      rd(RDC, 6'h05, D1, 1'h0);
      rd(RDC, 6'h09, ~D1, 1'h0);
      $display("test global done");
   endtask
   task automatic t_lanes();
      sbs_ctrl_t c;
      c = GWR;
      c.allLanesWriteN = 1'h1;
      c.laneAWriteSelectN = 1'h0;
      c.laneCWriteSelectN = 1'h0;
      wr(c, 6'h05, '1);
      // No write enable made that a read, which drives the pins a clock
      @(posedge clk);
      c.laneWriteEnableN = 1'h0;
      wr(c, 6'h05, '1);
      rd(RDC, 6'h05, {D1[35:27], 9'h1ff, D1[17:9], 9'h1ff}, 1'h0);
      c = ~c;
      c.processorAddrStrobeN = 1'h1;
      c.controllerAddrStrobeN = 1'h0;
      c.burstAdvanceN = 1'h1;
      c.laneWriteEnableN = 1'h0;
      c.allLanesWriteN = 1'h1;
      c.chipSelectFirstN = 1'h0;
      c.chipSelectSecond = 1'h1;
      c.chipSelectThirdN = 1'h0;
      wr(c, 6'h05, '0);
      rd(RDC, 6'h05, LX, 1'h0);
      $display("test lanes done");
   endtask
   task automatic t_select();
      sbs_ctrl_t c [3];
      c[0] = GWR;
      c[0].chipSelectFirstN = 1'h1;
      c[1] = GWR;
      c[1].chipSelectSecond = 1'h0;
      c[2] = GWR;
      c[2].chipSelectThirdN = 1'h1;
      for (int i = 0; i < 3; i++) wr(c[i], 6'h09, D1);
      rd(RDC, 6'h09, ~D1, 1'h0);
      c[0] = RDC;
      c[0].chipSelectFirstN = 1'h1;
      rd(c[0], 6'h05, ~D1, 1'h1);
      // Ignored processor strobe inside a read must not end the burst
      @(posedge clk);
      ctrl <= RDC;
      address <= 6'h09;
      @(posedge clk);
      ctrl <= c[0];
      @(posedge clk);
      ctrl <= DES;
      @(posedge clk);
      #1 chk_data(dqOut, ~D1);
      chk_bit(dqOutEnN, 1'h0);
      c[1] = GWR;
      c[1].processorAddrStrobeN = 1'h0;
      rd(c[1], 6'h05, LX, 1'h0);
      rd(RDC, 6'h05, LX, 1'h0);
      $display("test select done");
   endtask
   // Linear write burst from seed 2; a held edge rewrites address 7
   task automatic t_burst();
      sbs_ctrl_t c;
      sbs_ctrl_t h;
      logic [AW-1:0] a [4] = '{6'h06, 6'h07, 6'h04, 6'h05};
      logic [DW-1:0] e [4] = '{36'h0, 36'h2, 36'h3, 36'h4};
      c = IDLE;
      c.allLanesWriteN = 1'h0;
      c.burstAdvanceN = 1'h0;
      h = c;
      h.burstAdvanceN = 1'h1;
      @(posedge clk);
      ctrl <= GWR;
      address <= 6'h06;
      hostData <= 36'h0;
      hostDrive <= 1'h1;
      @(posedge clk);
      ctrl <= c;
      hostData <= 36'h1;
      @(posedge clk);
      ctrl <= h;
      hostData <= 36'h2;
      for (int i = 3; i < 5; i++) begin
         @(posedge clk);
         ctrl <= c;
         hostData <= DW'(i);
      end
      @(posedge clk);
      ctrl <= DES;
      hostDrive <= 1'h0;
      for (int i = 0; i < 4; i++) rd(RDC, a[i], e[i], 1'h0);
      $display("test burst done");
   endtask
   // Interleaved read burst from seed 1: addresses 5, 4, 7, 6
   task automatic t_ilv();
      sbs_ctrl_t c;
      logic [DW-1:0] e [4] = '{36'h4, 36'h3, 36'h2, 36'h0};
      c = IDLE;
      c.burstAdvanceN = 1'h0;
      @(posedge clk);
      burstOrderInterleave <= 1'h1;
      repeat (3) @(posedge clk);
      ctrl <= RDC;
      address <= 6'h05;
      @(posedge clk);
      ctrl <= c;
      for (int i = 0; i < 4; i++) begin
         @(posedge clk);
         if (i == 2) ctrl <= DES;
         #1 chk_data(dqOut, e[i]);
         chk_bit(dqOutEnN, 1'h0);
      end
      @(posedge clk);
      burstOrderInterleave <= 1'h0;
      $display("test interleave done");
   endtask
   task automatic t_oe();
      @(posedge clk);
      outputEnableN <= 1'h1;
      repeat (3) @(posedge clk);
      rd(RDC, 6'h09, ~D1, 1'h1);
      @(posedge clk);
      outputEnableN <= 1'h0;
      repeat (3) @(posedge clk);
      rd(RDC, 6'h05, 36'h4, 1'h0);
      $display("test output enable done");
   endtask
   task automatic end_of_test();
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////
   initial begin
      repeat (8) @(posedge clk);
      arst_n <= 1'h1;
      t_global();
      t_lanes();
      t_select();
      t_burst();
      t_ilv();
      t_oe();
      end_of_test();
   end
endmodule
